// file: rtl/ascp_pkg.sv
// Package for the converter start and readout control block.
// Assumes a single 40 MHz clock; all control inputs come from pins.
package ascp_pkg;

    localparam int          RESULT_WIDTH        = 12;
    localparam int          BYTE_WIDTH          = 8;
    localparam int          NIBBLE_WIDTH        = 4;
    localparam int          CLK_PERIOD_PS       = 25000;
    localparam int          SETUP_TIME_NS       = 50;
    localparam int          SETUP_CYCLES        = (SETUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                                  / CLK_PERIOD_PS;
    localparam int          FULL_CONV_CYCLES    = 800;
    localparam int          SHORT_CONV_CYCLES   = 534;
    localparam int          CNT_WIDTH           = 12;
    localparam int          DATA_BIT_THREE      = 3;
    localparam logic [11:0] RESULT_RESET        = 12'h000;
    localparam logic [11:0] SHORT_FILL          = 12'h008;
    localparam logic [11:0] UPPER_BYTE_LANES    = 12'hFF0;
    localparam logic [11:0] LOWER_BYTE_LANES    = 12'h0FF;

    typedef enum logic [1:0] {
        ASCP_IDLE    = 2'b00,
        ASCP_CONVERT = 2'b01,
        ASCP_DONE    = 2'b10
    } ascp_state_type;

    typedef struct packed {
        logic chip_enable;
        logic chip_sel_n;
        logic read_conv;
        logic word_sel;
        logic byte_addr_sel;
    } ascp_ctrl_type;

    typedef struct packed {
        logic [11:0] data;
        logic [11:0] oe;
    } ascp_bus_type;

endpackage

// file: rtl/ascp_sync.sv
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to the local clock.
`timescale 1ns/1ps
`default_nettype none
module ascp_sync
    import ascp_pkg::*;
#(
    parameter int WIDTH = 5
) (
    input  wire logic             ref_clk_in,
    input  wire logic             reset_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stage_one <= '0;
            sync_out  <= '0;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule
`default_nettype wire

// file: rtl/ascp_ctrl.sv
// Start and readout control of a 12-bit successive-approximation converter.
// Assumes pin inputs asynchronous to ref_clk_in and an external result source.
`timescale 1ns/1ps
`default_nettype none
module ascp_ctrl
    import ascp_pkg::*;
#(
    parameter int FULL_CYCLES  = FULL_CONV_CYCLES,
    parameter int SHORT_CYCLES = SHORT_CONV_CYCLES
) (
    input  wire logic                    ref_clk_in,
    input  wire logic                    reset_n_in,
    input  wire logic                    chip_enable_in,
    input  wire logic                    chip_sel_n_in,
    input  wire logic                    read_conv_in,
    input  wire logic                    word_sel_in,
    input  wire logic                    byte_addr_sel_in,
    input  wire logic [RESULT_WIDTH-1:0] result_in,
    output logic                         conv_busy_out,
    output logic                         short_mode_out,
    output logic      [RESULT_WIDTH-1:0] data_out,
    output logic      [RESULT_WIDTH-1:0] data_oe_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisation.

    ascp_ctrl_type  raw_ctrl;
    ascp_ctrl_type  ctrl;
    ascp_state_type state;
    logic           start_level;
    logic           start_prev;
    logic           start_edge;
    logic           short_latched;
    logic [CNT_WIDTH-1:0] conv_count;
    logic [RESULT_WIDTH-1:0] result_reg;
    logic           read_ok;
    logic           byte_prev;
    logic           byte_gap;
    ascp_bus_type   next_bus;

    assign raw_ctrl = '{chip_enable:   chip_enable_in,
                        chip_sel_n:    chip_sel_n_in,
                        read_conv:     read_conv_in,
                        word_sel:      word_sel_in,
                        byte_addr_sel: byte_addr_sel_in};

    ascp_sync #(
        .WIDTH    (5)
    ) u_sync (
        .ref_clk_in (ref_clk_in),
        .reset_n_in (reset_n_in),
        .async_in   (raw_ctrl),
        .sync_out   (ctrl)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    // Chip enable high together with chip select low.
    function automatic logic chip_picked(
        input logic enable,
        input logic select_n
    );
        return enable & ~select_n;
    endfunction

    // Enable pattern of the twelve lines for one read format.
    function automatic logic [RESULT_WIDTH-1:0] lane_enables(
        input logic word_wide,
        input logic low_byte
    );
        logic [RESULT_WIDTH-1:0] lanes;
        lanes = '0;
        if (word_wide) begin
            lanes = '1;
        end else if (!low_byte) begin
            lanes = UPPER_BYTE_LANES;
        end else begin
            lanes = LOWER_BYTE_LANES;
        end
        return lanes;
    endfunction

    // High while the byte address moved in this or the last cycle.
    function automatic logic byte_moving(
        input logic now_sel,
        input logic last_sel,
        input logic gap
    );
        return gap | (now_sel ^ last_sel);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Start detection.

    // The start condition is one combined level, so whichever input arrives last
    // makes the edge, and all three may change together.
    assign start_level = chip_picked(ctrl.chip_enable, ctrl.chip_sel_n) & ~ctrl.read_conv;
    assign start_edge  = start_level & ~start_prev;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            start_prev <= 1'b0;
        end else begin
            start_prev <= start_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencing.

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state         <= ASCP_IDLE;
            conv_count    <= '0;
            short_latched <= 1'b0;
        end else begin
            case (state)
                ASCP_IDLE, ASCP_DONE: begin
                    if (start_edge) begin
                        state         <= ASCP_CONVERT;
                        short_latched <= ctrl.byte_addr_sel;
                        conv_count    <= ctrl.byte_addr_sel ?
                                         CNT_WIDTH'(SHORT_CYCLES - 1) :
                                         CNT_WIDTH'(FULL_CYCLES - 1);
                    end
                end
                ASCP_CONVERT: begin
                    // Starts are not looked at here, so a running conversion holds.
                    if (conv_count == '0) begin
                        state <= ASCP_DONE;
                    end else begin
                        conv_count <= conv_count - CNT_WIDTH'(1);
                    end
                end
                default: begin
                    state <= ASCP_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status outputs.

    assign conv_busy_out  = (state == ASCP_CONVERT);
    assign short_mode_out = short_latched;

    ////////////////////////////////////////////////////////////////////////////
    // Result capture.

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            result_reg <= RESULT_RESET;
        end else if (state == ASCP_CONVERT && conv_count == '0) begin
            if (short_latched) begin
                result_reg <= {result_in[RESULT_WIDTH-1:NIBBLE_WIDTH], SHORT_FILL[3:0]};
            end else begin
                result_reg <= result_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output drive.

    // In byte reads, a byte change blanks all lines for two cycles before the new byte drives.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            byte_prev <= 1'b0;
            byte_gap  <= 1'b0;
        end else begin
            byte_prev <= ctrl.byte_addr_sel;
            byte_gap  <= ctrl.byte_addr_sel ^ byte_prev;
        end
    end

    assign read_ok = ctrl.read_conv & ~conv_busy_out
                     & chip_picked(ctrl.chip_enable, ctrl.chip_sel_n);

    always_comb begin
        next_bus.data = result_reg;
        next_bus.oe   = '0;
        if (read_ok && !conv_busy_out) begin
            if (!ctrl.word_sel && ctrl.byte_addr_sel) begin
                next_bus.data = {4'h0, 4'h0, result_reg[3:0]};
            end
            if (ctrl.word_sel) begin
                next_bus.oe = lane_enables(1'b1, ctrl.byte_addr_sel);
            end else if (!byte_moving(ctrl.byte_addr_sel, byte_prev, byte_gap)) begin
                next_bus.oe = lane_enables(1'b0, ctrl.byte_addr_sel);
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            data_out    <= RESULT_RESET;
            data_oe_out <= '0;
        end else begin
            data_out    <= next_bus.data;
            data_oe_out <= (state == ASCP_CONVERT) ? '0 : next_bus.oe;
        end
    end

endmodule
`default_nettype wire

// file: bench/ascp_ctrl_properties.sv
// Port checker for the converter start and readout control.
// Assumes a bind to ascp_ctrl in the bench top file.
`timescale 1ns/1ps
`default_nettype none
module ascp_ctrl_props
    import ascp_pkg::*;
#(
    parameter int FULL_CYCLES  = 10,
    parameter int SHORT_CYCLES = 6
) (
    input wire logic        ref_clk_in,
    input wire logic        reset_n_in,
    input wire logic        chip_enable_in,
    input wire logic        chip_sel_n_in,
    input wire logic        read_conv_in,
    input wire logic        conv_busy_out,
    input wire logic        short_mode_out,
    input wire logic [11:0] data_out,
    input wire logic [11:0] data_oe_out
);
    logic        start;
    logic [11:0] busy_len;
    assign start = chip_enable_in & ~chip_sel_n_in & ~read_conv_in;
    // Counts the cycles of the running conversion.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) busy_len <= 12'h000;
        else busy_len <= conv_busy_out ? busy_len + 12'h001 : 12'h000;
    end
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    a_busy_hides_data: assert property (conv_busy_out |-> data_oe_out == 12'h000)
        else $error("lines driven while busy");
    a_read_gates_oe: assert property (
        (!read_conv_in || !chip_enable_in || chip_sel_n_in) [*4] |-> data_oe_out == 12'h000)
        else $error("lines driven without read");
    a_oe_legal_set: assert property (
        data_oe_out inside {12'h000, 12'hFFF, 12'hFF0, 12'h0FF})
        else $error("illegal enable pattern");
    a_low_byte_zero: assert property (data_oe_out == 12'h0FF |-> data_out[7:4] == 4'h0)
        else $error("bits 4 to 7 not low");
    a_break_make: assert property (
        !(data_oe_out == 12'hFF0 && $past(data_oe_out) == 12'h0FF)
        && !(data_oe_out == 12'h0FF && $past(data_oe_out) == 12'hFF0)) else $error("byte overlap");
    a_busy_length: assert property ($fell(conv_busy_out)
        |-> int'(busy_len) == (short_mode_out ? SHORT_CYCLES : FULL_CYCLES)) else $error("bad length");
    a_short_fill: assert property (short_mode_out && data_oe_out == 12'hFFF
        |-> data_out[3:0] == 4'h8) else $error("short fill wrong");
    a_start_busy: assert property (
        !conv_busy_out && $rose(start) ##1 start [*2] |-> ##[0:1] conv_busy_out)
        else $error("start not taken");
endmodule
`default_nettype wire

// file: bench/ascp_host_bus.sv
// Host data bus model that resolves the twelve data lines.
// Assumes a line is driven while its enable is high.
`timescale 1ns/1ps
`default_nettype none
module ascp_host_bus (
    input  wire logic        ref_clk_in,
    input  wire logic [11:0] data_in,
    input  wire logic [11:0] oe_in,
    output logic      [11:0] bus_out
);
    // Released lines show a pattern that flips every cycle.
    logic [11:0] float_pat = 12'h5A5;
    always_ff @(posedge ref_clk_in) float_pat <= ~float_pat;
    assign bus_out = (data_in & oe_in) | (float_pat & ~oe_in);
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the converter start and readout control.
// Assumes the package, design, checker and host bus model compile first.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ascp_pkg::*;
;
    localparam int          FULL  = 10;
    localparam int          SHORT = 6;
    localparam logic [11:0] RES   = 12'hA5C;
    logic          ref_clk_in = 1'b0;
    logic          reset_n_in = 1'b0;
    ascp_ctrl_type ctl        = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    logic          busy;
    logic          short_mode;
    logic [11:0]   dat;
    logic [11:0]   oe;
    logic [11:0]   bus;
    int            fail_count      = 0;
    int            samples_checked = 0;
    int            ticks           = 0;
    ascp_ctrl #(.FULL_CYCLES(FULL), .SHORT_CYCLES(SHORT)) uut (
        .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .chip_enable_in(ctl.chip_enable), .chip_sel_n_in(ctl.chip_sel_n),
        .read_conv_in(ctl.read_conv), .word_sel_in(ctl.word_sel),
        .byte_addr_sel_in(ctl.byte_addr_sel), .result_in(RES),
        .conv_busy_out(busy), .short_mode_out(short_mode), .data_out(dat), .data_oe_out(oe));
    ascp_host_bus host (.ref_clk_in(ref_clk_in), .data_in(dat), .oe_in(oe), .bus_out(bus));
    initial forever #12.5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        ticks++;
        if (ticks == 3000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #2;
    endtask
    task automatic chk(input logic [11:0] exp, input logic [11:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic close_out();
        $display("Mismatches %0d of %0d", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Starts a conversion with input t as trigger (3: all); rs retries a start while busy.
    task automatic conv(input int t, input logic ba, input logic rs);
        int n;
        n = 0;
        ctl = '{1'b0, 1'b1, 1'b1, 1'b1, ba};
        cyc(3);
        ctl = '{!(t == 0 || t == 3), t == 1 || t == 3, t == 2 || t == 3, 1'b1, ba};
        cyc(2);
        ctl = '{1'b1, 1'b0, 1'b0, 1'b1, ba};
        while (!busy && n < 8) begin
            n++;
            cyc(1);
        end
        n = 0;
        while (busy && n < 40) begin
            if (rs) ctl.read_conv = (n == 2 || n == 3);
            if (rs) ctl.byte_addr_sel = n[0];
            n++;
            cyc(1);
            if (rs && n >= 4 && n <= 6) chk(12'h000, oe);
        end
        chk(ba ? 12'(SHORT) : 12'(FULL), 12'(n));
    endtask
    task automatic rd(input logic ws, input logic ba, input logic [11:0] eoe, input logic [11:0] ed);
        ctl = '{1'b1, 1'b0, 1'b1, ws, ba};
        cyc(5);
        chk(eoe, oe);
        chk(ed & eoe, bus & eoe);
    endtask
    task automatic full_word();
        conv(2, 1'b0, 1'b0);
        rd(1'b1, 1'b1, 12'hFFF, RES);
    endtask
    task automatic short_bytes();
        conv(0, 1'b1, 1'b0);
        chk(12'h001, {11'h000, short_mode});
        rd(1'b1, 1'b0, 12'hFFF, {RES[11:4], 4'h8});
        rd(1'b0, 1'b0, 12'hFF0, RES);
        rd(1'b0, 1'b1, 12'h0FF, 12'h008);
        rd(1'b0, 1'b0, 12'hFF0, RES);
    endtask
    task automatic restart_ignored();
        conv(1, 1'b0, 1'b1);
        chk(12'h000, {11'h000, short_mode});
        rd(1'b1, 1'b0, 12'hFFF, RES);
        ctl.chip_sel_n = 1'b1;
        cyc(5);
        chk(12'h000, oe);
    endtask
    task automatic all_at_once();
        conv(3, 1'b0, 1'b0);
        rd(1'b0, 1'b1, 12'h0FF, {8'h00, RES[3:0]});
    endtask
    initial begin
        cyc(10);
        reset_n_in = 1'b1;
        cyc(2);
        full_word();
        short_bytes();
        restart_ignored();
        all_at_once();
        close_out();
    end
endmodule
bind ascp_ctrl ascp_ctrl_props #(.FULL_CYCLES(FULL_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) u_props (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .chip_enable_in(chip_enable_in),
    .chip_sel_n_in(chip_sel_n_in), .read_conv_in(read_conv_in), .conv_busy_out(conv_busy_out),
    .short_mode_out(short_mode_out), .data_out(data_out), .data_oe_out(data_oe_out));
`default_nettype wire
